//--- sps_pkg.sv
package sps_pkg;

  // ---------------------------------------------------------------------------
  // Clock and timing
  // ---------------------------------------------------------------------------
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned PULSE_WIDTH_US = 4;
  localparam int unsigned PULSE_WIDTH_CYC =
    (PULSE_WIDTH_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SECOND_S = 1;
  localparam int unsigned SECOND_CYC = SECOND_S * CLK_HZ;
  localparam int unsigned ALMANAC_WEEKS = 8;
  localparam longint unsigned ALMANAC_FLUSH_CYC =
    64'(ALMANAC_WEEKS) * 64'd604800 * 64'(CLK_HZ);
  localparam int unsigned EPH_AGE_MAX_MIN = 120;
  localparam int unsigned POS_ERR_MAX_KM = 100;
  localparam int unsigned TIME_ERR_MAX_MIN = 5;

  // ---------------------------------------------------------------------------
  // Pulse output modes and sensitivity values
  // ---------------------------------------------------------------------------
  typedef enum logic [1:0] {
    SPS_MODE_OFF = 2'h0,
    SPS_MODE_ON = 2'h1,
    SPS_MODE_FIX = 2'h2
  } sps_mode_t;

  localparam sps_mode_t MODE_RESET = SPS_MODE_ON;
  localparam logic SENS_STANDARD = 1'b0;
  localparam logic SENS_ENHANCED = 1'b1;
  localparam logic SENS_RESET = SENS_STANDARD;

  // ---------------------------------------------------------------------------
  // Command and report codes
  // ---------------------------------------------------------------------------
  localparam logic [7:0] CMD_SENS = 8'h69;
  localparam logic [7:0] RPT_SENS = 8'h89;
  localparam logic [7:0] CMD_SOFT_RESET = 8'h25;
  localparam logic [7:0] RPT_VERSION = 8'h45;
  localparam logic [7:0] CMD_TIMING_OPT = 8'h35;
  localparam logic [7:0] RPT_NONE = 8'h00;

  // ---------------------------------------------------------------------------
  // Carriers
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic [7:0] id;
    logic has_data;
    logic [7:0] byte0;
  } sps_cmd_t;

  typedef struct packed {
    logic [7:0] id;
    logic [7:0] byte0;
    logic [7:0] byte1;
  } sps_rpt_t;

  typedef struct packed {
    logic eph_fresh;
    logic pos_near;
    logic time_near;
  } sps_aid_t;

endpackage : sps_pkg

//--- sps_pulse_gen.sv
`timescale 1ns/1ns
// -----------------------------------------------------------------------------
// Once-per-second pulse generator
// -----------------------------------------------------------------------------
module sps_pulse_gen (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic reset_in,
  input wire logic clk_en_in,
  // Alignment
  input wire logic align_in,
  // Pulse
  output logic pulse_out,
  output logic epoch_out
);

  logic [24:0] sec_cnt_reg;
  logic [7:0] wid_cnt_reg;

  // Free-running second counter, realigned by the steering tick.
  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      sec_cnt_reg <= 25'h0;
    end else if (clk_en_in) begin
      if (align_in || sec_cnt_reg == 25'(sps_pkg::SECOND_CYC - 1)) begin
        sec_cnt_reg <= 25'h0;
      end else begin
        sec_cnt_reg <= sec_cnt_reg + 25'h1;
      end
    end
  end

  // The epoch marks the start of each second.
  assign epoch_out = clk_en_in &&
    (align_in || sec_cnt_reg == 25'(sps_pkg::SECOND_CYC - 1));

  // Width counter stretches the epoch into a fixed-width pulse.
  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      wid_cnt_reg <= 8'h0;
      pulse_out <= 1'b0;
    end else if (clk_en_in) begin
      if (epoch_out) begin
        wid_cnt_reg <= 8'(sps_pkg::PULSE_WIDTH_CYC - 1);
        pulse_out <= 1'b1;
      end else if (wid_cnt_reg != 8'h0) begin
        wid_cnt_reg <= wid_cnt_reg - 8'h1;
      end else begin
        pulse_out <= 1'b0;
      end
    end
  end

endmodule : sps_pulse_gen

//--- sps_top.sv
`timescale 1ns/1ns
// How it works
// - Sensitivity query with no data answers with current and after-reset modes.
// - Factory state reports standard for both sensitivity values.
// - Command byte 1 sets only the after-reset value; current stays.
// - Soft reset copies after-reset into current and answers version report.
// - Unsaved mode lasts until cold start or power cycle, then stored value.
// - Save command writes sensitivity into flash, surviving cold starts.
// - Stored almanac is discarded automatically every eight weeks.
// - Hot start only with valid almanac, fresh ephemeris, near position, time.
// - Pulse edge sits on the receiver clock grid for steering.
// - Positive four microsecond pulse once per second, aligned while fixing.
// - Default mode pulses from power-up on backup timing, through lock loss.
// - Timing-options command selects pulse mode; save stores it.
// - Always-off holds the pulse low at once, fixes unaffected.
// - Always-on is the factory default and can be entered any time.
// - Fix-based mode pulses only while fixes are valid.
// - Week numbers count from week zero, January 6, 1980.
module sps_top #(
  parameter longint unsigned ALMANAC_FLUSH_CYC = sps_pkg::ALMANAC_FLUSH_CYC
) (
  // Clock, reset and enable
  input wire logic sys_clk_in,
  input wire logic reset_in,
  input wire logic clk_en_in,
  // Command port from the packet decoder
  input wire logic cmd_valid_in,
  input wire sps_pkg::sps_cmd_t cmd_in,
  input wire logic cold_start_in,
  input wire logic save_config_to_flash_cmd_in,
  // Flash image loaded at power-up
  input wire logic flash_valid_in,
  input wire logic flash_sens_in,
  input wire logic [1:0] flash_mode_in,
  // Navigation status
  input wire logic fix_valid_in,
  input wire logic almanac_load_in,
  input wire sps_pkg::sps_aid_t aid_in,
  // Receiver clock grid steering tick (external clock domain)
  input wire logic grid_tick_in,
  // Report port to the packet encoder
  output logic rpt_valid_out,
  output sps_pkg::sps_rpt_t rpt_out,
  // Flash write request
  output logic flash_wr_out,
  output logic flash_wr_sens_out,
  output logic [1:0] flash_wr_mode_out,
  // Status
  output logic sens_cur_out,
  output logic sens_pend_out,
  output logic [1:0] pulse_mode_out,
  output logic almanac_valid_out,
  output logic hot_start_out,
  // Timing pulse
  output logic second_tick_pulse_out
);

  // ---------------------------------------------------------------------------
  // Configuration state
  // ---------------------------------------------------------------------------
  // Three copies of the sensitivity: in force,
  // pending for the next soft reset, and stored.
  // Only a soft reset puts the pending value in
  // force; a save stores the pending value.
  logic sens_cur_reg;
  logic sens_pend_reg;
  logic sens_saved_reg;
  sps_pkg::sps_mode_t mode_reg;
  sps_pkg::sps_mode_t mode_saved_reg;
  logic boot_reg;

  // Code three is unused: it falls back to
  // always-on so a bad image cannot mute the pin.
  // Decodes a raw two-bit mode, falling back to the default on bad codes.
  function automatic sps_pkg::sps_mode_t to_mode(input logic [1:0] raw);
    sps_pkg::sps_mode_t m;
    m = sps_pkg::MODE_RESET;
    if (raw == 2'h0) begin
      m = sps_pkg::SPS_MODE_OFF;
    end else if (raw == 2'h1) begin
      m = sps_pkg::SPS_MODE_ON;
    end else if (raw == 2'h2) begin
      m = sps_pkg::SPS_MODE_FIX;
    end
    return m;
  endfunction : to_mode

  // Unknown ids are ignored without a report.
  // A timing-options command with no data byte
  // changes nothing.
  // Command strobes decoded from the id.
  logic is_sens;
  logic is_reset;
  logic is_timing;
  assign is_sens = cmd_valid_in && cmd_in.id == sps_pkg::CMD_SENS;
  assign is_reset = cmd_valid_in && cmd_in.id == sps_pkg::CMD_SOFT_RESET;
  assign is_timing = cmd_valid_in && cmd_in.id == sps_pkg::CMD_TIMING_OPT &&
    cmd_in.has_data;

  // The image wins over any command on the
  // boot edge, so the decoder should hold off
  // for one enabled cycle after reset.
  // Without a valid image the reset values stand.
  // Boot flag: flash image is taken on the first enabled edge after reset.
  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      boot_reg <= 1'b1;
    end else if (clk_en_in) begin
      boot_reg <= 1'b0;
    end
  end

  // The stored copy stands for the flash
  // contents; a cold start falls back to it.
  // A save on the boot edge updates the stored copy only without a valid image, and never requests a flash write.
  // Stored copy: from flash at boot, updated by the save command.
  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      sens_saved_reg <= sps_pkg::SENS_RESET;
      mode_saved_reg <= sps_pkg::MODE_RESET;
    end else if (clk_en_in) begin
      if (boot_reg && flash_valid_in) begin
        sens_saved_reg <= flash_sens_in;
        mode_saved_reg <= to_mode(flash_mode_in);
      end else if (save_config_to_flash_cmd_in) begin
        sens_saved_reg <= sens_pend_reg;
        mode_saved_reg <= mode_reg;
      end
    end
  end

  // Cold start beats soft reset, which beats a
  // write; a write lost to a cold start must be
  // sent again.
  // The report still echoes the lost write.
  // Sensitivity: pending set by command, current taken on soft reset.
  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      sens_cur_reg <= sps_pkg::SENS_RESET;
      sens_pend_reg <= sps_pkg::SENS_RESET;
    end else if (clk_en_in) begin
      if (boot_reg && flash_valid_in) begin
        sens_cur_reg <= flash_sens_in;
        sens_pend_reg <= flash_sens_in;
      end else if (cold_start_in) begin
        sens_cur_reg <= sens_saved_reg;
        sens_pend_reg <= sens_saved_reg;
      end else if (is_reset) begin
        sens_cur_reg <= sens_pend_reg;
      end else if (is_sens && cmd_in.has_data) begin
        sens_pend_reg <= cmd_in.byte0[0];
      end
    end
  end

  // The pulse mode, unlike the sensitivity,
  // acts at once: the gate below reads this
  // register directly.
  // A cold start restores the stored mode.
  // Pulse mode field, switched at once by the timing-options command.
  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      mode_reg <= sps_pkg::MODE_RESET;
    end else if (clk_en_in) begin
      if (boot_reg && flash_valid_in) begin
        mode_reg <= to_mode(flash_mode_in);
      end else if (cold_start_in) begin
        mode_reg <= mode_saved_reg;
      end else if (is_timing) begin
        mode_reg <= to_mode(cmd_in.byte0[1:0]);
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Reports and flash requests
  // ---------------------------------------------------------------------------
  // Report bytes come from the registers as they
  // stood before the command edge, except byte
  // one, which echoes the value being written.
  // Version bytes are zero; the encoder fills them.
  // A report is issued one cycle after each sensitivity or reset command.
  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      rpt_valid_out <= 1'b0;
      rpt_out <= '0;
    end else if (clk_en_in) begin
      rpt_valid_out <= 1'b0;
      if (is_sens) begin
        rpt_valid_out <= 1'b1;
        rpt_out.id <= sps_pkg::RPT_SENS;
        rpt_out.byte0 <= {7'h0, sens_cur_reg};
        rpt_out.byte1 <= {7'h0, cmd_in.has_data ? cmd_in.byte0[0] :
          sens_pend_reg};
      end else if (is_reset) begin
        rpt_valid_out <= 1'b1;
        rpt_out.id <= sps_pkg::RPT_VERSION;
        rpt_out.byte0 <= 8'h0;
        rpt_out.byte1 <= 8'h0;
      end
    end
  end

  // Data stays put between requests, so a slow
  // flash writer may sample it at any time up
  // to the next save.
  // One-cycle flash write request carrying the configuration.
  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      flash_wr_out <= 1'b0;
      flash_wr_sens_out <= sps_pkg::SENS_RESET;
      flash_wr_mode_out <= sps_pkg::MODE_RESET;
    end else if (clk_en_in) begin
      flash_wr_out <= save_config_to_flash_cmd_in && !boot_reg;
      if (save_config_to_flash_cmd_in) begin
        flash_wr_sens_out <= sens_pend_reg;
        flash_wr_mode_out <= mode_reg;
      end
    end
  end

  // Status ports mirror the registers directly.
  assign sens_cur_out = sens_cur_reg;
  assign sens_pend_out = sens_pend_reg;
  assign pulse_mode_out = mode_reg;

  // ---------------------------------------------------------------------------
  // Almanac age and hot-start qualification
  // ---------------------------------------------------------------------------
  // The flush interval is weeks long, so the
  // age counter is sixty-four bits wide.
  logic [63:0] alm_age_reg;

  // A load restarts the count and beats a flush
  // in the same cycle, so a fresh almanac is
  // never dropped at once.
  // A flush clears the count for the next load.
  // Age counter discards the almanac once the flush interval elapses.
  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      alm_age_reg <= 64'h0;
      almanac_valid_out <= 1'b0;
    end else if (clk_en_in) begin
      if (almanac_load_in) begin
        alm_age_reg <= 64'h0;
        almanac_valid_out <= 1'b1;
      end else if (almanac_valid_out) begin
        if (alm_age_reg >= ALMANAC_FLUSH_CYC - 64'h1) begin
          almanac_valid_out <= 1'b0;
          alm_age_reg <= 64'h0;
        end else begin
          alm_age_reg <= alm_age_reg + 64'h1;
        end
      end
    end
  end

  // Aiding flags are on this clock already; the
  // result is registered for a clean level.
  // Hot start needs all four aiding conditions at once.
  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      hot_start_out <= 1'b0;
    end else if (clk_en_in) begin
      hot_start_out <= almanac_valid_out && aid_in.eph_fresh &&
        aid_in.pos_near && aid_in.time_near;
    end
  end

  // ---------------------------------------------------------------------------
  // Pulse steering and gating
  // ---------------------------------------------------------------------------
  // The third grid flop holds the previous
  // synchronised level for the edge detector.
  logic grid_s1_reg;
  logic grid_s2_reg;
  logic grid_s3_reg;
  logic fix_s1_reg;
  logic fix_s2_reg;
  logic align;
  logic raw_pulse;

  // Grid tick and fix cross into this domain;
  // each passes two flops before use. The third
  // grid flop only delays it for edge finding.
  // Two-flop synchronisers for the grid tick and fix status.
  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      grid_s1_reg <= 1'b0;
      grid_s2_reg <= 1'b0;
      grid_s3_reg <= 1'b0;
      fix_s1_reg <= 1'b0;
      fix_s2_reg <= 1'b0;
    end else if (clk_en_in) begin
      grid_s1_reg <= grid_tick_in;
      grid_s2_reg <= grid_s1_reg;
      grid_s3_reg <= grid_s2_reg;
      fix_s1_reg <= fix_valid_in;
      fix_s2_reg <= fix_s1_reg;
    end
  end

  // Without a fix the counter keeps its own
  // second as backup, so the raw pulse never stops.
  // Steering moves the epoch in whole cycles.
  // Only a fix lets the grid restart the second.
  // Realign only while fixing; otherwise the counter free-runs as backup.
  assign align = fix_s2_reg && grid_s2_reg && !grid_s3_reg;

  // The generator makes the raw pulse; here it is only gated.
  sps_pulse_gen u_gen (
    .sys_clk_in(sys_clk_in),
    .reset_in(reset_in),
    .clk_en_in(clk_en_in),
    .align_in(align),
    .pulse_out(raw_pulse),
    .epoch_out()
  );

  // The gate is registered so the pin never
  // glitches on a mode change. Turning off cuts
  // a running pulse on the next edge.
  // In fix mode a lost fix drops the pulse too.
  // Mode gating of the pulse output, registered.
  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      second_tick_pulse_out <= 1'b0;
    end else if (clk_en_in) begin
      case (mode_reg)
        sps_pkg::SPS_MODE_OFF: second_tick_pulse_out <= 1'b0;
        sps_pkg::SPS_MODE_FIX: begin
          second_tick_pulse_out <= raw_pulse && fix_s2_reg;
        end
        default: second_tick_pulse_out <= raw_pulse;
      endcase
    end
  end

endmodule : sps_top

//--- sps_top_asserts.sv
`timescale 1ns/1ns
// -----------------------------------------------------------
// Checker on the ports of the pulse and sensitivity block
// -----------------------------------------------------------
module sps_top_asserts #(
  parameter longint unsigned ALMANAC_FLUSH_CYC = 100
) (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic reset_in,
  input wire logic clk_en_in,
  // Command side
  input wire logic cmd_valid_in,
  input wire sps_pkg::sps_cmd_t cmd_in,
  input wire logic cold_start_in,
  input wire logic save_config_to_flash_cmd_in,
  input wire logic fix_valid_in,
  input wire logic almanac_load_in,
  // Outputs watched
  input wire logic rpt_valid_out,
  input wire sps_pkg::sps_rpt_t rpt_out,
  input wire logic flash_wr_out,
  input wire logic flash_wr_sens_out,
  input wire logic sens_cur_out,
  input wire logic sens_pend_out,
  input wire logic [1:0] pulse_mode_out,
  input wire logic almanac_valid_out,
  input wire logic second_tick_pulse_out
);
  default clocking @(posedge sys_clk_in);
  endclocking
  default disable iff (reset_in);
  logic take;
  logic [1:0] mode_req;
  logic [7:0] hi_cnt;
  // A command counts only when enabled and not beaten by a cold start.
  assign take = clk_en_in && cmd_valid_in && !cold_start_in;
  assign mode_req = (cmd_in.byte0[1:0] == 2'h3) ? 2'h1 : cmd_in.byte0[1:0];
  // Counts how many cycles the pulse has already been high.
  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      hi_cnt <= 8'h00;
    end else if (clk_en_in) begin
      hi_cnt <= second_tick_pulse_out ? hi_cnt + 8'h01 : 8'h00;
    end
  end
  property p_sens_rpt;
    take && cmd_in.id == sps_pkg::CMD_SENS |=> rpt_valid_out && rpt_out ==
      {sps_pkg::RPT_SENS, 7'h00, sens_cur_out, 7'h00, sens_pend_out};
  endproperty
  a_sens_rpt: assert property (p_sens_rpt)
    else $error("sensitivity report wrong");
  property p_sens_set;
    take && cmd_in.id == sps_pkg::CMD_SENS && cmd_in.has_data &&
      cmd_in.byte0 == 8'h01 |=> sens_pend_out && $stable(sens_cur_out);
  endproperty
  a_sens_set: assert property (p_sens_set)
    else $error("sensitivity write touched the wrong value");
  property p_soft;
    take && cmd_in.id == sps_pkg::CMD_SOFT_RESET |=> rpt_valid_out &&
      rpt_out.id == sps_pkg::RPT_VERSION && sens_cur_out == $past(sens_pend_out);
  endproperty
  a_soft: assert property (p_soft)
    else $error("soft reset did not apply the pending value");
  property p_save;
    clk_en_in && save_config_to_flash_cmd_in && !cmd_valid_in && !cold_start_in
      |=> flash_wr_out && flash_wr_sens_out == $past(sens_pend_out);
  endproperty
  a_save: assert property (p_save)
    else $error("save did not write the pending value");
  property p_cold;
    clk_en_in && cold_start_in |=> sens_cur_out == sens_pend_out;
  endproperty
  a_cold: assert property (p_cold)
    else $error("cold start left values apart");
  property p_mode;
    take && cmd_in.id == sps_pkg::CMD_TIMING_OPT && cmd_in.has_data
      |=> pulse_mode_out == $past(mode_req);
  endproperty
  a_mode: assert property (p_mode)
    else $error("pulse mode not applied");
  property p_off;
    (pulse_mode_out == 2'h0) [*3] |-> !second_tick_pulse_out;
  endproperty
  a_off: assert property (p_off)
    else $error("pulse seen in off mode");
  property p_fix;
    (pulse_mode_out == 2'h2 && !fix_valid_in) [*5] |-> !second_tick_pulse_out;
  endproperty
  a_fix: assert property (p_fix)
    else $error("pulse seen in fix mode without fix");
  property p_width;
    second_tick_pulse_out |-> hi_cnt < 8'h50;
  endproperty
  a_width: assert property (p_width)
    else $error("pulse longer than its width");
  property p_alm;
    clk_en_in && almanac_load_in |=> almanac_valid_out;
  endproperty
  a_alm: assert property (p_alm)
    else $error("almanac not valid after load");
endmodule : sps_top_asserts
bind sps_top sps_top_asserts #(.ALMANAC_FLUSH_CYC(ALMANAC_FLUSH_CYC))
  u_sps_top_asserts (.*);

//--- sps_host_model.sv
`timescale 1ns/1ns
// -----------------------------------------------------------
// Host model that sends commands and takes reports
// -----------------------------------------------------------
module sps_host_model (
  // Clock and report port
  input wire logic sys_clk_in,
  input wire logic rpt_valid_in,
  input wire sps_pkg::sps_rpt_t rpt_in,
  // Command lines
  output logic cmd_valid_out,
  output sps_pkg::sps_cmd_t cmd_out,
  output logic cold_start_out,
  output logic save_out
);
  // All command lines start idle.
  initial begin
    cmd_valid_out = 1'b0;
    cmd_out = '0;
    cold_start_out = 1'b0;
    save_out = 1'b0;
  end
  // Sends one command and takes the report of the following cycle.
  task automatic send(input logic [7:0] id, input logic hd,
      input logic [7:0] b0, output logic got, output sps_pkg::sps_rpt_t r);
    @(posedge sys_clk_in);
    #5;
    cmd_out = '{id: id, has_data: hd, byte0: b0};
    cmd_valid_out = 1'b1;
    @(posedge sys_clk_in);
    #5;
    cmd_valid_out = 1'b0;
    cmd_out = ~cmd_out; // Released lines never keep the old value.
    got = rpt_valid_in;
    r = rpt_in;
  endtask : send
  // Pulses the cold start line, or the save line, for one cycle.
  task automatic strobe(input logic cold);
    @(posedge sys_clk_in);
    #5;
    if (cold) cold_start_out = 1'b1;
    else save_out = 1'b1;
    @(posedge sys_clk_in);
    #5;
    cold_start_out = 1'b0;
    save_out = 1'b0;
  endtask : strobe
endmodule : sps_host_model

//--- sps_top_test.sv
`timescale 1ns/1ns
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin fails++; \
  $display("mismatch %s exp %0h got %0h", nm, e, g); end end
// -----------------------------------------------------------
// Testbench of the pulse and sensitivity block
// -----------------------------------------------------------
module sps_top_test;
  logic sys_clk_in = 1'b0;
  logic reset_in = 1'b1;
  logic clk_en_in = 1'b1;
  logic cmd_valid, cold_start, save_cmd, got;
  sps_pkg::sps_cmd_t cmd;
  sps_pkg::sps_rpt_t rpt, r;
  logic flash_valid = 1'b0;
  logic flash_sens = 1'b0;
  logic [1:0] flash_mode = 2'h0;
  logic fix_valid = 1'b0;
  logic alm_load = 1'b0;
  logic grid_tick = 1'b0;
  sps_pkg::sps_aid_t aid = '0;
  logic rpt_valid, flash_wr, flash_wr_sens, sens_cur, sens_pend;
  logic alm_valid, hot_start, tick_pulse;
  logic [1:0] pulse_mode;
  int fails = 0;
  int n_compared = 0;
  int cycles = 0;
  int w;
  // Clock of 50 ns period.
  always #25 sys_clk_in = ~sys_clk_in;
  sps_top #(.ALMANAC_FLUSH_CYC(100)) u_sps_top (
    .sys_clk_in(sys_clk_in), .reset_in(reset_in), .clk_en_in(clk_en_in),
    .cmd_valid_in(cmd_valid), .cmd_in(cmd), .cold_start_in(cold_start),
    .save_config_to_flash_cmd_in(save_cmd), .flash_valid_in(flash_valid),
    .flash_sens_in(flash_sens), .flash_mode_in(flash_mode),
    .fix_valid_in(fix_valid), .almanac_load_in(alm_load), .aid_in(aid),
    .grid_tick_in(grid_tick), .rpt_valid_out(rpt_valid), .rpt_out(rpt),
    .flash_wr_out(flash_wr), .flash_wr_sens_out(flash_wr_sens),
    .flash_wr_mode_out(), .sens_cur_out(sens_cur), .sens_pend_out(sens_pend),
    .pulse_mode_out(pulse_mode), .almanac_valid_out(alm_valid),
    .hot_start_out(hot_start), .second_tick_pulse_out(tick_pulse));
  sps_host_model u_sps_host_model (
    .sys_clk_in(sys_clk_in), .rpt_valid_in(rpt_valid), .rpt_in(rpt),
    .cmd_valid_out(cmd_valid), .cmd_out(cmd), .cold_start_out(cold_start),
    .save_out(save_cmd));
  // Prints the counts and the verdict, then stops the run.
  task automatic test_done();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : test_done
  // Cuts a hang short.
  always @(posedge sys_clk_in) begin
    cycles++;
    if (cycles == 6000) begin
      fails++;
      test_done();
    end
  end
  // Resets with a given flash image; commands may follow at once.
  task automatic do_reset(input logic fv, input logic fs, input logic [1:0] fm);
    flash_valid = fv;
    flash_sens = fs;
    flash_mode = fm;
    reset_in = 1'b1;
    repeat (6) @(posedge sys_clk_in);
    #5;
    reset_in = 1'b0;
    repeat (2) @(posedge sys_clk_in);
    #5;
  endtask : do_reset
  // Sends a sensitivity command and compares the whole report.
  task automatic sens(input logic hd, input logic [7:0] b0, input logic [23:0] e);
    u_sps_host_model.send(sps_pkg::CMD_SENS, hd, b0, got, r);
    `CHK("rpt_valid", 1'b1, got)
    `CHK("rpt", e, r)
  endtask : sens
  // Selects a pulse mode through the timing-options command.
  task automatic mode(input logic [7:0] m);
    u_sps_host_model.send(sps_pkg::CMD_TIMING_OPT, 1'b1, m, got, r);
  endtask : mode
  // Raises the grid tick and counts high pulse cycles after the rise.
  task automatic tick(output int w);
    w = 0;
    grid_tick = 1'b1;
    repeat (120) begin
      @(posedge sys_clk_in);
      #5;
      if (tick_pulse === 1'b1) w++;
    end
    grid_tick = 1'b0;
    repeat (4) @(posedge sys_clk_in);
    #5;
  endtask : tick
  // Main sequence of tests.
  initial begin
    do_reset(1'b0, 1'b0, 2'h0);
    `CHK("pulse_mode", 2'h1, pulse_mode)
    sens(1'b0, 8'h00, 24'h890000);
    sens(1'b1, 8'h01, 24'h890001);
    u_sps_host_model.send(sps_pkg::CMD_SOFT_RESET, 1'b0, 8'h00, got, r);
    `CHK("version", sps_pkg::RPT_VERSION, r.id)
    sens(1'b0, 8'h00, 24'h890101);
    u_sps_host_model.strobe(1'b1);
    `CHK("sens_cur", 1'b0, sens_cur)
    `CHK("sens_pend", 1'b0, sens_pend)
    $display("test sensitivity done");
    sens(1'b1, 8'h01, 24'h890001);
    u_sps_host_model.send(sps_pkg::CMD_SOFT_RESET, 1'b0, 8'h00, got, r);
    u_sps_host_model.strobe(1'b0);
    `CHK("flash_wr", 1'b1, flash_wr)
    `CHK("flash_wr_sens", 1'b1, flash_wr_sens)
    u_sps_host_model.strobe(1'b1);
    `CHK("sens_cur", 1'b1, sens_cur)
    do_reset(1'b1, 1'b1, 2'h2);
    `CHK("sens_cur", 1'b1, sens_cur)
    `CHK("pulse_mode", 2'h2, pulse_mode)
    clk_en_in = 1'b0;
    mode(8'h00);
    `CHK("frozen_mode", 2'h2, pulse_mode)
    clk_en_in = 1'b1;
    $display("test flash done");
    for (int m = 0; m < 4; m++) begin
      mode(8'(m));
      `CHK("pulse_mode", (m == 3) ? 2'h1 : 2'(m), pulse_mode)
    end
    fix_valid = 1'b1;
    tick(w);
    `CHK("width", 80, w)
    grid_tick = 1'b1;
    repeat (20) @(posedge sys_clk_in);
    mode(8'h00);
    @(posedge sys_clk_in);
    #5;
    `CHK("pulse_cut", 1'b0, tick_pulse)
    grid_tick = 1'b0;
    repeat (4) @(posedge sys_clk_in);
    #5;
    tick(w);
    `CHK("width_off", 0, w)
    fix_valid = 1'b0;
    mode(8'h02);
    tick(w);
    `CHK("width_nofix", 0, w)
    fix_valid = 1'b1;
    tick(w);
    `CHK("width_fix", 80, w)
    grid_tick = 1'b1;
    w = 0;
    repeat (40) begin
      @(posedge sys_clk_in);
      #5;
      if (tick_pulse === 1'b1) w++;
      if (w == 8) fix_valid = 1'b0;
    end
    grid_tick = 1'b0;
    `CHK("width_lost", 10, w)
    $display("test pulse done");
    aid = '1;
    repeat (3) @(posedge sys_clk_in);
    #5;
    `CHK("hot_noalm", 1'b0, hot_start)
    alm_load = 1'b1;
    @(posedge sys_clk_in);
    #5;
    alm_load = 1'b0;
    `CHK("alm_valid", 1'b1, alm_valid)
    repeat (3) @(posedge sys_clk_in);
    #5;
    `CHK("hot", 1'b1, hot_start)
    aid.time_near = 1'b0;
    repeat (3) @(posedge sys_clk_in);
    #5;
    `CHK("hot_far", 1'b0, hot_start)
    repeat (93) @(posedge sys_clk_in);
    #5;
    `CHK("alm_kept", 1'b1, alm_valid)
    @(posedge sys_clk_in);
    #5;
    `CHK("alm_flushed", 1'b0, alm_valid)
    $display("test almanac done");
    test_done();
  end
endmodule : sps_top_test
